// ==== agu_pkg.sv ====
// Package of modes, sizes, widths and cost figures for the address generation unit.
package agu_pkg;
  localparam int ADDR_W = 24;
  localparam int DATA_W = 16;
  localparam int REG_IDX_W = 3;
  localparam int NUM_PTR = 8;
  localparam logic [2:0] SP_IDX = 3'h7;
  localparam logic [2:0] OFS_IDX = 3'h6;
  localparam logic [2:0] OFS3_IDX = 3'h3;
  localparam logic [23:0] PTR_RST = 24'h000000;
  localparam logic [23:0] STEP_ONE = 24'h000001;
  localparam logic [23:0] STEP_TWO = 24'h000002;
  localparam logic [1:0] CYC_NONE = 2'h0;
  localparam logic [1:0] CYC_ONE = 2'h1;
  localparam logic [1:0] CYC_TWO = 2'h2;
  localparam logic [1:0] EXT_NONE = 2'h0;
  localparam logic [1:0] EXT_ONE = 2'h1;
  localparam logic [1:0] EXT_TWO = 2'h2;

  typedef enum logic [3:0] {
    AGU_REG_DIRECT = 4'h0,
    AGU_NO_UPDATE = 4'h1,
    AGU_POST_INC = 4'h2,
    AGU_POST_DEC = 4'h3,
    AGU_POST_OFS = 4'h4,
    AGU_INDEX_OFS = 4'h5,
    AGU_DISP3 = 4'h6,
    AGU_DISP6 = 4'h7,
    AGU_DISP16 = 4'h8,
    AGU_DISP24 = 4'h9
  } agu_mode_t;

  typedef enum logic [1:0] {
    AGU_SZ_BYTE = 2'h0,
    AGU_SZ_WORD = 2'h1,
    AGU_SZ_LONG = 2'h2
  } agu_size_t;

  typedef struct packed {
    agu_mode_t mode;
    agu_size_t size;
    logic byte_pointer_move;
    logic [2:0] ptr_sel;
    logic use_secondary;
    logic [5:0] short_disp;
    logic [23:0] ext_disp;
    logic [2:0] src_a;
    logic [2:0] src_b;
    logic [2:0] src_c;
  } agu_req_t;

  typedef struct packed {
    logic [23:0] addr;
    logic mem_access;
    logic [1:0] extra_cycles;
    logic [1:0] ext_words;
    logic modulo;
  } agu_resp_t;
endpackage

// ==== agu_ptr_file.sv ====
// Pointer register file with registered read ports and one write port.
`timescale 1ns/10ps
module agu_ptr_file #(
  parameter int WIDTH = 24,
  parameter int DEPTH = 8
) (
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  input wire logic i_we,
  input wire logic [2:0] i_waddr,
  input wire logic [WIDTH-1:0] i_wdata,
  input wire logic [2:0] i_raddr_a,
  input wire logic [2:0] i_raddr_b,
  input wire logic [2:0] i_raddr_c,
  output logic [WIDTH-1:0] o_rdata_a,
  output logic [WIDTH-1:0] o_rdata_b,
  output logic [WIDTH-1:0] o_rdata_c,
  output logic [WIDTH-1:0] o_all [DEPTH]
);
  logic [WIDTH-1:0] mem_q [DEPTH];

  always_ff @(posedge i_core_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      for (int k = 0; k < DEPTH; k++)
        mem_q[k] <= '0;
      o_rdata_a <= '0;
      o_rdata_b <= '0;
      o_rdata_c <= '0;
    end
    else
    begin
      if (i_we)
        mem_q[i_waddr] <= i_wdata;
      o_rdata_a <= mem_q[i_raddr_a];
      o_rdata_b <= mem_q[i_raddr_b];
      o_rdata_c <= mem_q[i_raddr_c];
    end
  end

  assign o_all = mem_q;
endmodule // agu_ptr_file

// ==== agu_effective_address_calc.sv ====
// Effective address calculation and pointer write-back for the address generation unit.
//
// Notes on behaviour
// - Register-direct mode reads up to three operand registers and makes no memory access.
// - Post-decrement uses the pointer's current value as address and subtracts afterwards.
// - Post-increment adds one for byte or word and two for long, written back to the same pointer.
// - Post-decrement subtracts two for long and one otherwise, written back to the same pointer.
// - A halved stack-relative displacement is shifted left one bit for long accesses.
// - The modulo flag on the first two pointers follows the modifier register; pointer arithmetic here is always linear.
// - No-update mode uses the pointer as address and leaves it unchanged.
// - Post-update by offset sign-extends the offset's low 16 bits and adds them to the pointer.
// - Index by offset adds the signed 24-bit offset, doubled for long, and modifies nothing.
// - A 3-bit displacement is one-extended with the stack pointer and zero-extended otherwise.
// - The 6-bit stack displacement is one-extended to -1..-64 and doubled for long.
// - A 16-bit displacement is signed, except for byte pointer moves where it is zero-extended.
// - A 16-bit displacement is doubled for long accesses and counted in bytes for byte accesses.
// - A 24-bit signed displacement is added, doubled for long and in bytes for byte accesses.
// - Disp24 costs two cycles, index and short or 16-bit displacements one, post-updates none.
// - The 16-bit displacement mode consumes exactly one extension word.
`timescale 1ns/10ps
module agu_effective_address_calc #(
  parameter int ADDR_W = agu_pkg::ADDR_W
) (
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  input wire logic i_req_valid,
  input wire agu_pkg::agu_req_t i_req,
  input wire logic [1:0] i_modulo_modifier_reg,
  input wire logic i_load_en,
  input wire logic [2:0] i_load_sel,
  input wire logic [23:0] i_load_data,
  output agu_pkg::agu_resp_t o_resp,
  output logic o_resp_valid,
  output logic [23:0] o_opnd_a,
  output logic [23:0] o_opnd_b,
  output logic [23:0] o_opnd_c
);
  logic [23:0] ptr_all [agu_pkg::NUM_PTR];
  logic [23:0] address_pointer_reg;
  logic [23:0] secondary_offset_reg;
  logic [23:0] stack_ptr_reg;
  logic [23:0] disp_raw;
  logic [23:0] disp_scaled;
  logic [23:0] post_step;
  logic [23:0] ea_d;
  logic [23:0] wb_data;
  logic wb_en;
  logic is_long;
  logic is_sp;
  logic [1:0] cyc_d;
  logic [1:0] ext_d;
  logic mod_d;
  agu_pkg::agu_resp_t resp_q;
  logic resp_valid_q;
  logic [2:0] ra_d;
  logic [2:0] rb_d;
  logic [2:0] rc_d;
  logic wr_en;
  logic [2:0] wr_sel;
  logic [23:0] wr_data;
  logic [2:0] ofs_sel;

  function automatic logic [23:0] scale_long(input logic [23:0] v, input logic lng);
    scale_long = lng ? {v[22:0], 1'b0} : v;
  endfunction

  assign is_long = (i_req.size == agu_pkg::AGU_SZ_LONG);
  assign is_sp = (i_req.ptr_sel == agu_pkg::SP_IDX);
  assign address_pointer_reg = ptr_all[i_req.ptr_sel];
  assign ofs_sel = i_req.use_secondary ? agu_pkg::OFS3_IDX : agu_pkg::OFS_IDX;
  assign secondary_offset_reg = ptr_all[ofs_sel];
  assign stack_ptr_reg = ptr_all[agu_pkg::SP_IDX];

  // Raw displacement before size scaling; byte accesses keep byte units unscaled.
  always_comb
  begin
    disp_raw = '0;
    case (i_req.mode)
      agu_pkg::AGU_INDEX_OFS: disp_raw = secondary_offset_reg;
      agu_pkg::AGU_DISP3: disp_raw = is_sp ? {21'h1fffff, i_req.short_disp[2:0]}
                                           : {21'h000000, i_req.short_disp[2:0]};
      agu_pkg::AGU_DISP6: disp_raw = {18'h3ffff, i_req.short_disp};
      agu_pkg::AGU_DISP16: disp_raw = i_req.byte_pointer_move ? {8'h00, i_req.ext_disp[15:0]}
                                      : {{8{i_req.ext_disp[15]}}, i_req.ext_disp[15:0]};
      agu_pkg::AGU_DISP24: disp_raw = i_req.ext_disp;
      default: disp_raw = '0;
    endcase
  end

  // The encoder stores long displacements halved, so doubling restores the true offset.
  assign disp_scaled = scale_long(disp_raw, is_long);

  always_comb
  begin
    post_step = '0;
    wb_en = 1'b0;
    case (i_req.mode)
      agu_pkg::AGU_POST_INC:
      begin
        post_step = is_long ? agu_pkg::STEP_TWO : agu_pkg::STEP_ONE;
        wb_en = 1'b1;
      end
      agu_pkg::AGU_POST_DEC:
      begin
        post_step = is_long ? (~agu_pkg::STEP_TWO + 24'h000001) : (~agu_pkg::STEP_ONE + 24'h000001);
        wb_en = 1'b1;
      end
      agu_pkg::AGU_POST_OFS:
      begin
        post_step = {{8{secondary_offset_reg[15]}}, secondary_offset_reg[15:0]};
        wb_en = 1'b1;
      end
      default:
      begin
        post_step = '0;
        wb_en = 1'b0;
      end
    endcase
  end

  // Post modes address at the old pointer; indexed modes at pointer plus displacement.
  assign ea_d = address_pointer_reg + disp_scaled;
  assign wb_data = address_pointer_reg + post_step;

  always_comb
  begin
    cyc_d = agu_pkg::CYC_NONE;
    ext_d = agu_pkg::EXT_NONE;
    case (i_req.mode)
      agu_pkg::AGU_INDEX_OFS, agu_pkg::AGU_DISP3, agu_pkg::AGU_DISP6: cyc_d = agu_pkg::CYC_ONE;
      agu_pkg::AGU_DISP16:
      begin
        cyc_d = agu_pkg::CYC_ONE;
        ext_d = agu_pkg::EXT_ONE;
      end
      agu_pkg::AGU_DISP24:
      begin
        cyc_d = agu_pkg::CYC_TWO;
        ext_d = agu_pkg::EXT_TWO;
      end
      default:
      begin
        cyc_d = agu_pkg::CYC_NONE;
        ext_d = agu_pkg::EXT_NONE;
      end
    endcase
  end

  // Modulo updates themselves are not built here; the flag tells the downstream wrap logic.
  assign mod_d = ((i_req.ptr_sel == 3'h0) || (i_req.ptr_sel == 3'h1))
                 && (i_modulo_modifier_reg != 2'h0);

  assign ra_d = (i_req.mode == agu_pkg::AGU_REG_DIRECT) ? i_req.src_a : 3'h0;
  assign rb_d = (i_req.mode == agu_pkg::AGU_REG_DIRECT) ? i_req.src_b : 3'h0;
  assign rc_d = (i_req.mode == agu_pkg::AGU_REG_DIRECT) ? i_req.src_c : 3'h0;

  // A pointer write-back outranks a decoder load in the same cycle.
  assign wr_en = (i_req_valid && wb_en) || i_load_en;
  assign wr_sel = (i_req_valid && wb_en) ? i_req.ptr_sel : i_load_sel;
  assign wr_data = (i_req_valid && wb_en) ? wb_data : i_load_data;

  agu_ptr_file #(
    .WIDTH(agu_pkg::ADDR_W),
    .DEPTH(agu_pkg::NUM_PTR)
  ) u_ptr_file (
    .i_core_clk(i_core_clk),
    .i_rst_n(i_rst_n),
    .i_we(wr_en),
    .i_waddr(wr_sel),
    .i_wdata(wr_data),
    .i_raddr_a(ra_d),
    .i_raddr_b(rb_d),
    .i_raddr_c(rc_d),
    .o_rdata_a(o_opnd_a),
    .o_rdata_b(o_opnd_b),
    .o_rdata_c(o_opnd_c),
    .o_all(ptr_all)
  );

  always_ff @(posedge i_core_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      resp_q <= '0;
      resp_valid_q <= 1'b0;
    end
    else
    begin
      resp_valid_q <= i_req_valid;
      if (i_req_valid)
      begin
        resp_q.addr <= ea_d;
        resp_q.mem_access <= (i_req.mode != agu_pkg::AGU_REG_DIRECT);
        resp_q.extra_cycles <= cyc_d;
        resp_q.ext_words <= ext_d;
        resp_q.modulo <= mod_d;
      end
    end
  end

  assign o_resp = resp_q;
  assign o_resp_valid = resp_valid_q;

  sequence post_req_s;
    i_req_valid && !i_load_en && (i_req.mode == agu_pkg::AGU_POST_INC) && !is_long;
  endsequence

  post_inc_step_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    post_req_s |=> (ptr_all[$past(i_req.ptr_sel)] == $past(address_pointer_reg) + 24'h000001))
    else $error("post increment step wrong");

  post_dec_long_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    (i_req_valid && i_req.mode == agu_pkg::AGU_POST_DEC && is_long)
    |=> (ptr_all[$past(i_req.ptr_sel)] == $past(address_pointer_reg) - 24'h000002))
    else $error("post decrement long step wrong");

  post_dec_addr_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    (i_req_valid && i_req.mode == agu_pkg::AGU_POST_DEC) |=> (o_resp.addr == $past(address_pointer_reg)))
    else $error("post decrement address not old pointer");

  no_update_hold_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    (i_req_valid && !i_load_en && i_req.mode == agu_pkg::AGU_NO_UPDATE)
    |=> (ptr_all[$past(i_req.ptr_sel)] == $past(address_pointer_reg)))
    else $error("no update changed pointer");

  reg_direct_nomem_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    (i_req_valid && i_req.mode == agu_pkg::AGU_REG_DIRECT) |=> !o_resp.mem_access)
    else $error("register direct made memory access");

  disp24_cost_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    (i_req_valid && i_req.mode == agu_pkg::AGU_DISP24) |=> (o_resp.extra_cycles == 2'h2 && o_resp.ext_words == 2'h2))
    else $error("disp24 cost wrong");

  disp16_ext_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    (i_req_valid && i_req.mode == agu_pkg::AGU_DISP16) |=> (o_resp.ext_words == 2'h1))
    else $error("disp16 extension count wrong");

  disp6_long_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    (i_req_valid && i_req.mode == agu_pkg::AGU_DISP6 && is_long)
    |=> (o_resp.addr == $past(address_pointer_reg) + {$past({17'h1ffff, i_req.short_disp}), 1'b0}))
    else $error("disp6 long address wrong");

  disp3_sp_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    (i_req_valid && i_req.mode == agu_pkg::AGU_DISP3 && is_sp && !is_long)
    |=> (o_resp.addr == $past(stack_ptr_reg) + $past({21'h1fffff, i_req.short_disp[2:0]})))
    else $error("disp3 stack offset wrong");

  modulo_select_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    (i_req_valid && i_req.ptr_sel > 3'h1) |=> !o_resp.modulo)
    else $error("modulo flag on upper pointer");

  post_inc_long_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    (i_req_valid && i_req.mode == agu_pkg::AGU_POST_INC && is_long)
    |=> (ptr_all[$past(i_req.ptr_sel)] == $past(address_pointer_reg) + 24'h000002))
    else $error("post increment long step wrong");

  post_dec_word_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    (i_req_valid && i_req.mode == agu_pkg::AGU_POST_DEC && !is_long)
    |=> (ptr_all[$past(i_req.ptr_sel)] == $past(address_pointer_reg) - 24'h000001))
    else $error("post decrement step wrong");

  post_ofs_step_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    (i_req_valid && i_req.mode == agu_pkg::AGU_POST_OFS)
    |=> (ptr_all[$past(i_req.ptr_sel)]
         == $past(address_pointer_reg) + $past({{8{secondary_offset_reg[15]}}, secondary_offset_reg[15:0]})))
    else $error("post update by offset step wrong");

  post_ofs_keep_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    (i_req_valid && !i_load_en && i_req.mode == agu_pkg::AGU_POST_OFS && ofs_sel != i_req.ptr_sel)
    |=> (ptr_all[$past(ofs_sel)] == $past(secondary_offset_reg)))
    else $error("post update changed offset register");

  index_keep_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    (i_req_valid && !i_load_en && i_req.mode == agu_pkg::AGU_INDEX_OFS)
    |=> (ptr_all[$past(i_req.ptr_sel)] == $past(address_pointer_reg))
        && (ptr_all[$past(ofs_sel)] == $past(secondary_offset_reg)))
    else $error("index by offset changed a register");

  index_word_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    (i_req_valid && i_req.mode == agu_pkg::AGU_INDEX_OFS && !is_long)
    |=> (o_resp.addr == $past(address_pointer_reg) + $past(secondary_offset_reg)))
    else $error("index by offset address wrong");

  index_long_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    (i_req_valid && i_req.mode == agu_pkg::AGU_INDEX_OFS && is_long)
    |=> (o_resp.addr == $past(address_pointer_reg) + {$past(secondary_offset_reg[22:0]), 1'b0}))
    else $error("index by offset long address wrong");

  disp3_zero_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    (i_req_valid && i_req.mode == agu_pkg::AGU_DISP3 && !is_sp && !is_long)
    |=> (o_resp.addr == $past(address_pointer_reg) + $past({21'h000000, i_req.short_disp[2:0]})))
    else $error("disp3 positive offset wrong");

  disp6_word_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    (i_req_valid && i_req.mode == agu_pkg::AGU_DISP6 && !is_long)
    |=> (o_resp.addr == $past(address_pointer_reg) + $past({18'h3ffff, i_req.short_disp})))
    else $error("disp6 word address wrong");

  disp16_signed_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    (i_req_valid && i_req.mode == agu_pkg::AGU_DISP16 && !is_long && !i_req.byte_pointer_move)
    |=> (o_resp.addr == $past(address_pointer_reg) + $past({{8{i_req.ext_disp[15]}}, i_req.ext_disp[15:0]})))
    else $error("disp16 signed address wrong");

  disp16_bytes_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    (i_req_valid && i_req.mode == agu_pkg::AGU_DISP16 && !is_long && i_req.byte_pointer_move)
    |=> (o_resp.addr == $past(address_pointer_reg) + $past({8'h00, i_req.ext_disp[15:0]})))
    else $error("disp16 byte pointer address wrong");

  disp16_long_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    (i_req_valid && i_req.mode == agu_pkg::AGU_DISP16 && is_long && !i_req.byte_pointer_move)
    |=> (o_resp.addr == $past(address_pointer_reg) + {$past({{7{i_req.ext_disp[15]}}, i_req.ext_disp[15:0]}), 1'b0}))
    else $error("disp16 long address wrong");

  disp24_word_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    (i_req_valid && i_req.mode == agu_pkg::AGU_DISP24 && !is_long)
    |=> (o_resp.addr == $past(address_pointer_reg) + $past(i_req.ext_disp)))
    else $error("disp24 address wrong");

  disp24_long_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    (i_req_valid && i_req.mode == agu_pkg::AGU_DISP24 && is_long)
    |=> (o_resp.addr == $past(address_pointer_reg) + {$past(i_req.ext_disp[22:0]), 1'b0}))
    else $error("disp24 long address wrong");

  short_cost_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    (i_req_valid && (i_req.mode == agu_pkg::AGU_INDEX_OFS || i_req.mode == agu_pkg::AGU_DISP3
                     || i_req.mode == agu_pkg::AGU_DISP6))
    |=> (o_resp.extra_cycles == 2'h1 && o_resp.ext_words == 2'h0))
    else $error("short displacement cost wrong");

  post_cost_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    (i_req_valid && (i_req.mode == agu_pkg::AGU_POST_INC || i_req.mode == agu_pkg::AGU_POST_DEC
                     || i_req.mode == agu_pkg::AGU_POST_OFS))
    |=> (o_resp.extra_cycles == 2'h0 && o_resp.ext_words == 2'h0))
    else $error("post update cost wrong");

  disp16_cycle_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    (i_req_valid && i_req.mode == agu_pkg::AGU_DISP16) |=> (o_resp.extra_cycles == 2'h1))
    else $error("disp16 cycle count wrong");

  mem_access_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    (i_req_valid && i_req.mode != agu_pkg::AGU_REG_DIRECT) |=> o_resp.mem_access)
    else $error("indirect mode made no memory access");

  reg_direct_read_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    (i_req_valid && i_req.mode == agu_pkg::AGU_REG_DIRECT)
    |=> (o_opnd_a == $past(ptr_all[i_req.src_a])) && (o_opnd_b == $past(ptr_all[i_req.src_b]))
        && (o_opnd_c == $past(ptr_all[i_req.src_c])))
    else $error("register direct operand wrong");

  modulo_low_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    (i_req_valid && i_req.ptr_sel <= 3'h1) |=> (o_resp.modulo == ($past(i_modulo_modifier_reg) != 2'h0)))
    else $error("modulo flag does not follow modifier");

  resp_valid_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    i_req_valid |=> o_resp_valid)
    else $error("answer strobe missing");

  resp_idle_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    !i_req_valid |=> (!o_resp_valid && $stable(o_resp)))
    else $error("answer changed without a request");
endmodule // agu_effective_address_calc

// ==== agu_mem_bus_model.sv ====
// Data memory address bus model that counts memory-access answers and keeps the last memory-access address the block presents.
`timescale 1ns/10ps
module agu_mem_bus_model (
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  input wire logic i_resp_valid,
  input wire agu_pkg::agu_resp_t i_resp,
  output logic [23:0] o_last_addr,
  output int o_count
);
  // Register-direct answers carry no memory access, so the bus ignores them.
  always_ff @(posedge i_core_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_last_addr <= 24'h000000;
      o_count <= 0;
    end
    else if (i_resp_valid && i_resp.mem_access)
    begin
      o_last_addr <= i_resp.addr;
      o_count <= o_count + 1;
    end
  end
endmodule // agu_mem_bus_model

// ==== agu_effective_address_calc_tb.sv ====
// Self-checking testbench for the effective address calculation block.
`timescale 1ns/10ps
module agu_effective_address_calc_tb;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic req_valid = 1'b0;
  agu_pkg::agu_req_t req = '0;
  logic [1:0] mod_reg = 2'h0;
  logic load_en = 1'b0;
  logic [2:0] load_sel = 3'h0;
  logic [23:0] load_data = 24'h000000;
  agu_pkg::agu_resp_t resp;
  logic resp_valid;
  logic [23:0] opnd_a;
  logic [23:0] opnd_b;
  logic [23:0] opnd_c;
  logic [23:0] mem_addr;
  int mem_cnt;
  int miscompares = 0;
  int cmp_count = 0;
  int n_mem = 0;
  int cycles = 0;

  always #20 clk = ~clk;

  agu_effective_address_calc u_dut (.i_core_clk(clk), .i_rst_n(rst_n), .i_req_valid(req_valid), .i_req(req),
    .i_modulo_modifier_reg(mod_reg), .i_load_en(load_en), .i_load_sel(load_sel), .i_load_data(load_data),
    .o_resp(resp), .o_resp_valid(resp_valid), .o_opnd_a(opnd_a), .o_opnd_b(opnd_b), .o_opnd_c(opnd_c));

  agu_mem_bus_model u_mem (.i_core_clk(clk), .i_rst_n(rst_n), .i_resp_valid(resp_valid), .i_resp(resp),
    .o_last_addr(mem_addr), .o_count(mem_cnt));

  task automatic conclude();
    $display("Comparisons %0d, mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // A hung handshake would otherwise stall the run forever.
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      miscompares++;
      conclude();
    end
  end

  task automatic check(input logic [23:0] got, input logic [23:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      miscompares++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // All driving tasks start and end on a falling edge.
  task automatic ld(input logic [2:0] idx, input logic [23:0] val);
    load_en = 1'b1;
    load_sel = idx;
    load_data = val;
    @(negedge clk);
    load_en = 1'b0;
    @(negedge clk);
  endtask

  task automatic issue(input agu_pkg::agu_mode_t m, input agu_pkg::agu_size_t s, input logic [2:0] p,
    input logic [5:0] sd, input logic [23:0] ed);
    req.mode = m;
    req.size = s;
    req.ptr_sel = p;
    req.short_disp = sd;
    req.ext_disp = ed;
    req_valid = 1'b1;
    @(negedge clk);
    req_valid = 1'b0;
    check({23'h000000, resp_valid}, 24'h000001);
    @(negedge clk);
    check({23'h000000, resp_valid}, 24'h000000);
  endtask

  // The ce argument packs extra cycles over extension words.
  task automatic op(input agu_pkg::agu_mode_t m, input agu_pkg::agu_size_t s, input logic [2:0] p,
    input logic [5:0] sd, input logic [23:0] ed, input logic [23:0] ea, input logic [3:0] ce);
    issue(m, s, p, sd, ed);
    n_mem++;
    check(resp.addr, ea);
    check({19'h00000, resp.mem_access, resp.extra_cycles, resp.ext_words}, {19'h00000, 1'b1, ce});
  endtask

  task automatic peek(input logic [2:0] idx, input logic [23:0] exp);
    req.src_a = idx;
    issue(agu_pkg::AGU_REG_DIRECT, agu_pkg::AGU_SZ_WORD, 3'h0, 6'h00, 24'h000000);
    check(opnd_a, exp);
    check({23'h000000, resp.mem_access}, 24'h000000);
  endtask

  task automatic t_direct();
    ld(3'h1, 24'h111111);
    ld(3'h2, 24'h222222);
    ld(3'h7, 24'h777777);
    req.src_b = 3'h2;
    req.src_c = 3'h7;
    peek(3'h1, 24'h111111);
    check(opnd_b, 24'h222222);
    check(opnd_c, 24'h777777);
  endtask

  task automatic t_post();
    ld(3'h5, 24'h000010);
    op(agu_pkg::AGU_POST_INC, agu_pkg::AGU_SZ_WORD, 3'h5, 6'h00, 24'h0, 24'h000010, 4'h0);
    op(agu_pkg::AGU_POST_INC, agu_pkg::AGU_SZ_LONG, 3'h5, 6'h00, 24'h0, 24'h000011, 4'h0);
    op(agu_pkg::AGU_POST_INC, agu_pkg::AGU_SZ_BYTE, 3'h5, 6'h00, 24'h0, 24'h000013, 4'h0);
    op(agu_pkg::AGU_POST_DEC, agu_pkg::AGU_SZ_LONG, 3'h5, 6'h00, 24'h0, 24'h000014, 4'h0);
    op(agu_pkg::AGU_POST_DEC, agu_pkg::AGU_SZ_WORD, 3'h5, 6'h00, 24'h0, 24'h000012, 4'h0);
    peek(3'h5, 24'h000011);
    ld(3'h0, 24'h000000);
    op(agu_pkg::AGU_POST_DEC, agu_pkg::AGU_SZ_WORD, 3'h0, 6'h00, 24'h0, 24'h000000, 4'h0);
    peek(3'h0, 24'hffffff);
    ld(3'h4, 24'habcdef);
    op(agu_pkg::AGU_NO_UPDATE, agu_pkg::AGU_SZ_LONG, 3'h4, 6'h00, 24'h0, 24'habcdef, 4'h0);
    peek(3'h4, 24'habcdef);
  endtask

  task automatic t_offset();
    ld(3'h6, 24'hab8000);
    ld(3'h2, 24'h001000);
    op(agu_pkg::AGU_POST_OFS, agu_pkg::AGU_SZ_WORD, 3'h2, 6'h00, 24'h0, 24'h001000, 4'h0);
    peek(3'h2, 24'hff9000);
    peek(3'h6, 24'hab8000);
    ld(3'h3, 24'h120010);
    ld(3'h1, 24'h000020);
    req.use_secondary = 1'b1;
    op(agu_pkg::AGU_POST_OFS, agu_pkg::AGU_SZ_WORD, 3'h1, 6'h00, 24'h0, 24'h000020, 4'h0);
    req.use_secondary = 1'b0;
    peek(3'h1, 24'h000030);
    ld(3'h6, 24'hfffffe);
    ld(3'h4, 24'h000100);
    op(agu_pkg::AGU_INDEX_OFS, agu_pkg::AGU_SZ_WORD, 3'h4, 6'h00, 24'h0, 24'h0000fe, 4'h4);
    op(agu_pkg::AGU_INDEX_OFS, agu_pkg::AGU_SZ_LONG, 3'h4, 6'h00, 24'h0, 24'h0000fc, 4'h4);
    peek(3'h4, 24'h000100);
  endtask

  task automatic t_disp();
    ld(3'h7, 24'h000200);
    ld(3'h1, 24'h000200);
    op(agu_pkg::AGU_DISP3, agu_pkg::AGU_SZ_WORD, 3'h7, 6'h05, 24'h0, 24'h0001fd, 4'h4);
    op(agu_pkg::AGU_DISP3, agu_pkg::AGU_SZ_WORD, 3'h7, 6'h00, 24'h0, 24'h0001f8, 4'h4);
    op(agu_pkg::AGU_DISP3, agu_pkg::AGU_SZ_WORD, 3'h1, 6'h07, 24'h0, 24'h000207, 4'h4);
    op(agu_pkg::AGU_DISP6, agu_pkg::AGU_SZ_WORD, 3'h7, 6'h00, 24'h0, 24'h0001c0, 4'h4);
    op(agu_pkg::AGU_DISP6, agu_pkg::AGU_SZ_LONG, 3'h7, 6'h3d, 24'h0, 24'h0001fa, 4'h4);
    ld(3'h2, 24'h010000);
    op(agu_pkg::AGU_DISP16, agu_pkg::AGU_SZ_WORD, 3'h2, 6'h00, 24'hab8000, 24'h008000, 4'h5);
    op(agu_pkg::AGU_DISP16, agu_pkg::AGU_SZ_LONG, 3'h2, 6'h00, 24'h00fff0, 24'h00ffe0, 4'h5);
    req.byte_pointer_move = 1'b1;
    op(agu_pkg::AGU_DISP16, agu_pkg::AGU_SZ_BYTE, 3'h2, 6'h00, 24'h008000, 24'h018000, 4'h5);
    req.byte_pointer_move = 1'b0;
    op(agu_pkg::AGU_DISP24, agu_pkg::AGU_SZ_WORD, 3'h7, 6'h00, 24'h800000, 24'h800200, 4'ha);
    op(agu_pkg::AGU_DISP24, agu_pkg::AGU_SZ_LONG, 3'h7, 6'h00, 24'hfffff0, 24'h0001e0, 4'ha);
    op(agu_pkg::AGU_DISP24, agu_pkg::AGU_SZ_BYTE, 3'h7, 6'h00, 24'h000003, 24'h000203, 4'ha);
  endtask

  task automatic t_modulo();
    for (int p = 0; p < 3; p++)
    begin
      mod_reg = 2'h1;
      issue(agu_pkg::AGU_NO_UPDATE, agu_pkg::AGU_SZ_WORD, 3'(p), 6'h00, 24'h0);
      n_mem++;
      check({23'h000000, resp.modulo}, {23'h000000, p < 2});
    end
    mod_reg = 2'h0;
    issue(agu_pkg::AGU_NO_UPDATE, agu_pkg::AGU_SZ_WORD, 3'h0, 6'h00, 24'h0);
    n_mem++;
    check({23'h000000, resp.modulo}, 24'h000000);
  endtask

  // Back-to-back requests keep the strobe up; the second must see the first write-back.
  task automatic t_burst();
    ld(3'h5, 24'h000040);
    req.mode = agu_pkg::AGU_POST_INC;
    req.size = agu_pkg::AGU_SZ_LONG;
    req.ptr_sel = 3'h5;
    req_valid = 1'b1;
    @(negedge clk);
    check(resp.addr, 24'h000040);
    @(negedge clk);
    req_valid = 1'b0;
    n_mem += 2;
    check(resp.addr, 24'h000042);
    @(negedge clk);
    check({23'h000000, resp_valid}, 24'h000000);
    peek(3'h5, 24'h000044);
  endtask

  // A mid-run reset must clear the pointers, the answer and the bus log.
  task automatic t_reset();
    rst_n = 1'b0;
    repeat (2) @(negedge clk);
    check(resp.addr, 24'h000000);
    check({23'h000000, resp_valid}, 24'h000000);
    check(24'(mem_cnt), 24'h000000);
    rst_n = 1'b1;
    n_mem = 0;
    peek(3'h7, 24'h000000);
    peek(3'h5, 24'h000000);
    ld(3'h0, 24'h0000a5);
  endtask

  initial
  begin
    repeat (4) @(posedge clk);
    @(negedge clk);
    rst_n = 1'b1;
    t_direct();
    t_post();
    t_burst();
    t_offset();
    t_disp();
    t_reset();
    t_modulo();
    @(negedge clk);
    check(24'(mem_cnt), 24'(n_mem));
    check(mem_addr, 24'h0000a5);
    conclude();
  end
endmodule // agu_effective_address_calc_tb
